// ===== hdl/mxl_defs.svh
// constants for the masked extract logic unit
`ifndef MXL_DEFS_SVH
`define MXL_DEFS_SVH
`define MXL_WORD_W 48
`define MXL_CHAR_W 6
`define MXL_CHAR_CODES 64
`define MXL_OP_W 3
`define MXL_ZERO_WORD 48'h0000_0000_0000
`endif

// ===== hdl/mxl_pkg.sv
// types for the masked extract logic unit
package mxl_pkg;
  typedef enum logic [2:0] {
    MXL_OP_NONE = 3'h0,
    MXL_OP_JUMP_ODD = 3'h1,
    MXL_OP_JUMP_EVEN = 3'h2,
    MXL_OP_D_OR_MEM = 3'h3,
    MXL_OP_EXT_D = 3'h4,
    MXL_OP_EXT_A = 3'h5,
    MXL_OP_EXT_ADD = 3'h6
  } mxl_op_t;
  typedef enum logic [1:0] {
    MXL_ST_IDLE = 2'h0,
    MXL_ST_EXEC = 2'h1,
    MXL_ST_DONE = 2'h2
  } mxl_state_t;
endpackage

// ===== hdl/mxl_unit.sv
// masked extract, merge and mask-rotate jump datapath
`timescale 1ns/1ps
`include "mxl_defs.svh"

module mxl_unit import mxl_pkg::*; #(
  parameter int WORD_W = `MXL_WORD_W,
  parameter int CHAR_W = `MXL_CHAR_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // request from the sequencer
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic [WORD_W-1:0] mem_word,
  // register loads from the sequencer
  input wire logic load_a,
  input wire logic load_q,
  input wire logic load_d,
  input wire logic [WORD_W-1:0] load_data,
  input wire logic overflow_set,
  input wire logic overflow_clr,
  // results
  output logic done,
  output logic jump_taken,
  output logic mem_write,
  output logic [WORD_W-1:0] mem_wdata,
  output logic [WORD_W-1:0] acc_q,
  output logic [WORD_W-1:0] mask_q,
  output logic [WORD_W-1:0] dreg_q,
  output logic overflow_q,
  output logic busy
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // character fields must tile the word; the unit is fixed at 48 bits
  initial begin
    if (WORD_W != `MXL_WORD_W) begin
      $error("mxl_unit: word width must be 48");
    end
    if (CHAR_W != `MXL_CHAR_W) begin
      $error("mxl_unit: character width must be 6");
    end
    if ((CHAR_W == 0) || ((WORD_W % CHAR_W) != 0)) begin
      $error("mxl_unit: characters must tile the word");
    end
    if ((1 << CHAR_W) != `MXL_CHAR_CODES) begin
      $error("mxl_unit: a character must give 64 codes");
    end
    // the op port and the op type must agree or codes would alias
    if ($bits(mxl_op_t) != `MXL_OP_W) begin
      $error("mxl_unit: op code width must be 3");
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // vector index 0 holds machine bit 47 (lsb), index WORD_W-1 bit 0 (msb)
  function automatic logic [WORD_W-1:0] masked(input logic [WORD_W-1:0] m,
                                               input logic [WORD_W-1:0] w);
    masked = m & w;
  endfunction

  // one place toward the lsb end, the old lsb wrapping round to the msb
  function automatic logic [WORD_W-1:0] rotate_lsb(input logic [WORD_W-1:0] w);
    rotate_lsb = {w[0], w[WORD_W-1:1]};
  endfunction

  // the two mask jumps share the rotate and differ only in the test
  function automatic logic is_mask_jump(input mxl_op_t op);
    is_mask_jump = (op == MXL_OP_JUMP_ODD) || (op == MXL_OP_JUMP_EVEN);
  endfunction

  // every extract variant rewrites the whole of D with the field
  function automatic logic is_extract(input mxl_op_t op);
    is_extract = (op == MXL_OP_EXT_D) || (op == MXL_OP_EXT_A) ||
                 (op == MXL_OP_EXT_ADD);
  endfunction

  // ----------------------------------------------------------------
  // datapath and decode
  // ----------------------------------------------------------------
  // state, captured operands and decoded strobes
  mxl_state_t state_q;
  mxl_op_t op_q;
  logic [WORD_W-1:0] word_q;
  logic in_idle;
  logic in_exec;
  logic accept;
  logic exec_jump;
  logic exec_merge;
  logic exec_extract;
  logic [WORD_W-1:0] field;
  logic [WORD_W-1:0] merged;
  logic [WORD_W-1:0] sum;

  assign in_idle = (state_q == MXL_ST_IDLE);
  assign in_exec = (state_q == MXL_ST_EXEC);
  // a strobe outside idle is dropped, the sequencer must wait until the cycle after done
  assign accept = in_idle && op_valid;
  assign exec_jump = in_exec && is_mask_jump(op_q);
  assign exec_merge = in_exec && (op_q == MXL_OP_D_OR_MEM);
  assign exec_extract = in_exec && is_extract(op_q);

  assign field = masked(mask_q, word_q);
  assign merged = dreg_q | word_q;
  // modulo the word width; the sum never reaches the overflow indicator
  assign sum = acc_q + field;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // done pulses one cycle after execution so all results are stable
  // first; a request in the done cycle is dropped, not queued
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_q <= MXL_ST_IDLE;
    end else begin
      case (state_q)
        MXL_ST_IDLE: begin
          if (accept) begin
            state_q <= MXL_ST_EXEC;
          end
        end
        MXL_ST_EXEC: begin
          state_q <= MXL_ST_DONE;
        end
        MXL_ST_DONE: begin
          state_q <= MXL_ST_IDLE;
        end
        default: begin
          state_q <= MXL_ST_IDLE;
        end
      endcase
    end
  end

  // operand capture: op and word are taken together on the accepting edge
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      op_q <= MXL_OP_NONE;
      word_q <= `MXL_ZERO_WORD;
    end else if (accept) begin
      op_q <= mxl_op_t'(op_code);
      word_q <= mem_word;
    end
  end

  // busy covers only the exec cycle; done marks the cycle after it,
  // so the two never stand together
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else begin
      busy <= accept;
    end
  end

  // ----------------------------------------------------------------
  // mask register
  // ----------------------------------------------------------------
  // circular toward the lsb end regardless of the test; a load arriving
  // while busy is dropped rather than queued
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mask_q <= `MXL_ZERO_WORD;
    end else if (exec_jump) begin
      mask_q <= rotate_lsb(mask_q);
    end else if (load_q && in_idle) begin
      mask_q <= load_data;
    end
  end

  // ----------------------------------------------------------------
  // overflow indicator
  // ----------------------------------------------------------------
  // only the sequencer touches it; the mask jumps do not
  // set wins when both requests meet in one cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      overflow_q <= 1'b0;
    end else if (overflow_set) begin
      overflow_q <= 1'b1;
    end else if (overflow_clr) begin
      overflow_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // D register
  // ----------------------------------------------------------------
  // the merge keeps every D one and adds those of the word; extracts
  // rewrite every bit of D, so no earlier bits survive
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      dreg_q <= `MXL_ZERO_WORD;
    end else if (exec_merge) begin
      dreg_q <= merged;
    end else if (exec_extract) begin
      dreg_q <= field;
    end else if (load_d && in_idle) begin
      dreg_q <= load_data;
    end
  end

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  // extract-to-D falls to the default hold branch
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      acc_q <= `MXL_ZERO_WORD;
    end else if (in_exec) begin
      case (op_q)
        MXL_OP_EXT_A: begin
          acc_q <= field;
        end
        MXL_OP_EXT_ADD: begin
          acc_q <= sum;
        end
        default: begin
          acc_q <= acc_q;
        end
      endcase
    end else if (load_a && in_idle) begin
      acc_q <= load_data;
    end
  end

  // ----------------------------------------------------------------
  // results to the sequencer
  // ----------------------------------------------------------------
  // done follows the exec cycle, so every register result is settled
  // before the sequencer acts on the jump or the store
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      done <= 1'b0;
    end else begin
      done <= in_exec;
    end
  end

  // the store strobe is one cycle wide and only for the merge
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mem_write <= 1'b0;
    end else begin
      mem_write <= exec_merge;
    end
  end

  // the write data follows the merge and holds until the next one
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mem_wdata <= `MXL_ZERO_WORD;
    end else if (exec_merge) begin
      mem_wdata <= merged;
    end
  end

  // the test uses the mask before rotation, sampled in the exec cycle;
  // the even test is simply the inverse of the odd one
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      jump_taken <= 1'b0;
    end else if (exec_jump) begin
      case (op_q)
        MXL_OP_JUMP_ODD: begin
          jump_taken <= mask_q[0];
        end
        MXL_OP_JUMP_EVEN: begin
          jump_taken <= ~mask_q[0];
        end
        default: begin
          jump_taken <= 1'b0;
        end
      endcase
    end else begin
      jump_taken <= 1'b0;
    end
  end

endmodule

// ===== tb/mxl_unit_props.sv
// assertions on the masked extract unit ports
`timescale 1ns/1ps
module mxl_unit_props import mxl_pkg::*; #(parameter int WORD_W = 48) (
  // watched ports
  input wire logic ref_clk, rst_b, op_valid, busy, done, jump_taken, mem_write, overflow_q,
  input wire logic [2:0] op_code,
  input wire logic [WORD_W-1:0] mem_word, acc_q, mask_q, dreg_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // operands held from the accepting edge so results are judged at done
  logic [2:0] po;
  logic [WORD_W-1:0] pa, pq, pd, pm;
  wire take = op_valid && !busy && !done;
  wire jd = done && po inside {[1:2]};
  wire xd = done && po inside {[4:6]};
  wire [WORD_W-1:0] fld = pq & pm;
  always_ff @(posedge ref_clk) begin
    if (take) {po, pa, pq, pd, pm} <= {op_code, acc_q, mask_q, dreg_q, mem_word};
  end
  chk_done_latency: assert property (take && op_code inside {[1:6]} |-> ##2 done)
    else $error("done late");
  chk_busy_done: assert property (busy |=> done && !busy)
    else $error("busy too long");
  chk_jump_test: assert property (jd |-> jump_taken == (pq[0] ^ po[1]))
    else $error("jump test");
  chk_mask_rotate: assert property (jd |-> mask_q == {pq[0], pq[WORD_W-1:1]})
    else $error("mask rotate");
  chk_flag_kept: assert property (take |=> $stable(overflow_q) [*2])
    else $error("overflow moved");
  chk_merge_store: assert property (done && po == 3 |-> mem_write && dreg_q == (pd | pm))
    else $error("merge");
  chk_extract_d: assert property (xd |-> dreg_q == fld && mask_q == pq)
    else $error("extract");
  chk_acc_result: assert property (xd |-> acc_q == (po == 4 ? pa : po == 5 ? fld : pa + fld))
    else $error("accumulator");
endmodule
bind mxl_unit mxl_unit_props #(.WORD_W(WORD_W)) u_mxl_unit_props (.*);

// ===== tb/mxl_mem_model.sv
// word memory standing for the sequencer side of the unit
`timescale 1ns/1ps
module mxl_mem_model (
  // access from the bench and the unit
  input wire logic ref_clk,
  input wire logic [3:0] addr,
  input wire logic mem_write,
  input wire logic [47:0] mem_wdata,
  output logic [47:0] mem_word
);
  logic [47:0] mem [16];
  assign mem_word = mem[addr];
  always @(posedge ref_clk) if (mem_write) mem[addr] <= mem_wdata;
endmodule

// ===== tb/test_mxl_unit.sv
// random and corner tests of the masked extract unit
`timescale 1ns/1ps
module test_mxl_unit import mxl_pkg::*; ;
  logic ref_clk = 1'b0, rst_b = 1'b0, op_valid = 1'b0, load_a = 1'b0, load_q = 1'b0;
  logic load_d = 1'b0, overflow_set = 1'b0, overflow_clr = 1'b0;
  logic done, jump_taken, mem_write, busy, overflow_q;
  logic [2:0] op_code = 3'h0;
  logic [3:0] addr = 4'h0;
  logic [47:0] load_data = 48'h0, mem_word, mem_wdata, acc_q, mask_q, dreg_q, ea, eq, ed, f;
  logic [47:0] sh [16];
  int n_mismatch = 0, n_checks = 0, seed = 82358;
  mxl_unit u_mxl_unit (.*);
  mxl_mem_model u_mxl_mem_model (.*);
  always #4 ref_clk = ~ref_clk;
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic ld(input logic [2:0] sel, input logic [47:0] v);
    {load_a, load_q, load_d} = sel;
    load_data = v;
    @(posedge ref_clk);
    #1 {load_a, load_q, load_d} = 3'h0;
    if (sel[2]) ea = v;
    if (sel[1]) eq = v;
    if (sel[0]) ed = v;
  endtask
  // one operation, then the done cycle the unit needs to leave before the next
  task automatic run(input logic [2:0] op, input logic [3:0] a);
    op_valid = 1'b1;
    op_code = op;
    addr = a;
    f = eq & sh[a];
    @(posedge ref_clk);
    #1 op_valid = 1'b0;
    @(posedge ref_clk);
    #1 chk(48'(done), 48'h1);
    if (op < 3) begin
      chk(48'(jump_taken), 48'(eq[0] ^ op[1]));
      eq = {eq[0], eq[47:1]};
    end else if (op == 3) begin
      ed = ed | sh[a];
      sh[a] = ed;
    end else begin
      ea = op == 4 ? ea : op == 5 ? f : ea + f;
      ed = f;
    end
    chk(acc_q, ea);
    chk(mask_q, eq);
    chk(dreg_q, ed);
    @(posedge ref_clk);
    #1 chk(mem_word, sh[a]);
  endtask
  initial begin
    for (int i = 0; i < 16; i++) begin
      sh[i] = 48'({$random(seed), $random(seed)});
      u_mxl_mem_model.mem[i] = sh[i];
    end
    {ea, eq, ed} = '0;
    repeat (6) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    overflow_set = 1'b1;
    ld(3'h2, 48'h0000_0000_0005);
    overflow_set = 1'b0;
    for (int k = 0; k < 50; k++) run(k[0] ? MXL_OP_JUMP_EVEN : MXL_OP_JUMP_ODD, 4'h0);
    chk(48'(overflow_q), 48'h1);
    $display("rotate test end");
    for (int k = 0; k < 150; k++) begin
      ld(k < 2 ? 3'h7 : 3'($random(seed)), k < 2 ? {48{k[0]}} : 48'({$random(seed), $random(seed)}));
      run(3'(1 + $unsigned($random(seed)) % 6), 4'($random(seed)));
    end
    $display("random test end");
    conclude();
  end
  initial begin
    #40000;
    n_mismatch++;
    conclude();
  end
endmodule
